//--- fpr_pkg.sv
// Shared constants and types for the flash read and write protection checker.
// Assumes one system clock domain and option bytes presented as stable levels.
package fpr_pkg;

  localparam int ADDR_W = 32;
  localparam int PAGE_W = 7;
  localparam int PAGE_SHIFT = 11;
  localparam int N_AREA = 4;
  localparam int AREA_PER_BANK = 2;

  // Read-protection byte pairs
  localparam logic [7:0] RDP_L0_BYTE = 8'hAA;
  localparam logic [7:0] RDP_L0_COMP = 8'h55;
  localparam logic [7:0] RDP_L2_BYTE = 8'hCC;
  localparam logic [7:0] RDP_L2_COMP = 8'h33;

  // Page size in bytes, start greater than end means an empty area
  localparam logic [ADDR_W-1:0] PAGE_BYTES = 32'h0000_0800;
  localparam logic [PAGE_W-1:0] AREA_NONE_START = 7'h7F;
  localparam logic [PAGE_W-1:0] AREA_NONE_END = 7'h00;

  // Flash bank base addresses
  localparam logic [ADDR_W-1:0] BANK1_BASE = 32'h0800_0000;
  localparam logic [ADDR_W-1:0] BANK2_BASE = 32'h0804_0000;

  typedef enum logic [1:0] {FPR_LVL0, FPR_LVL1, FPR_LVL2} fpr_level_t;

  typedef enum logic [1:0] {FPR_OP_READ, FPR_OP_PROGRAM, FPR_OP_ERASE, FPR_OP_MASS} fpr_op_t;

  typedef enum logic [2:0] {
    FPR_RG_MAIN, FPR_RG_SYSMEM, FPR_RG_OPTION, FPR_RG_BACKUP, FPR_RG_OTP, FPR_RG_NEVER
  } fpr_region_t;

  typedef enum logic [1:0] {FPR_BOOT_FLASH, FPR_BOOT_SRAM, FPR_BOOT_SYSMEM} fpr_boot_t;

  typedef struct packed {
    logic valid;
    logic from_debug;
    fpr_op_t op;
    fpr_region_t region;
    logic bank;
    logic [ADDR_W-1:0] addr;
  } fpr_req_t;

  typedef struct packed {
    logic [PAGE_W-1:0] start_page;
    logic [PAGE_W-1:0] end_page;
  } fpr_area_t;

  typedef struct packed {
    fpr_area_t area;
    fpr_area_t area_n;
  } fpr_area_nv_t;

endpackage

//--- fpr_rdp_decode.sv
// Decoder of the read-protection byte and its complement into a level.
// Assumes both bytes are stable while the loader samples the result.
module fpr_rdp_decode (
  input wire logic [7:0] rdp_byte_i,
  input wire logic [7:0] rdp_comp_i,
  output fpr_pkg::fpr_level_t level_o,
  output logic mismatch_o
);

  always_comb begin
    mismatch_o = (rdp_byte_i != ~rdp_comp_i);
    if (rdp_byte_i == fpr_pkg::RDP_L0_BYTE && rdp_comp_i == fpr_pkg::RDP_L0_COMP) begin
      level_o = fpr_pkg::FPR_LVL0;
    end else if (rdp_byte_i == fpr_pkg::RDP_L2_BYTE && rdp_comp_i == fpr_pkg::RDP_L2_COMP) begin
      level_o = fpr_pkg::FPR_LVL2;
    end else begin
      // Erased or corrupted pairs fall to the safe middle level
      level_o = fpr_pkg::FPR_LVL1;
    end
  end

endmodule

//--- fpr_area_match.sv
// Page comparator for one write-protected area.
// Assumes the page index and bank hit are computed by the caller.
module fpr_area_match (
  input wire fpr_pkg::fpr_area_t area_i,
  input wire logic [fpr_pkg::PAGE_W-1:0] page_i,
  input wire logic in_bank_i,
  output logic active_o,
  output logic hit_o
);

  always_comb begin
    // Start above end protects nothing, equal bounds protect one page
    active_o = (area_i.start_page <= area_i.end_page);
    hit_o = active_o && in_bank_i && (page_i >= area_i.start_page)
            && (page_i <= area_i.end_page);
  end

endmodule

//--- fpr_protect_top.sv
// Flash read and write protection checker: level decode, access gating, area checks.
// Assumes the flash controller performs erase and programming on the pulses given here.
module fpr_protect_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] nv_read_protection_byte_i,
  input wire logic [7:0] nv_read_protection_comp_i,
  input wire fpr_pkg::fpr_area_nv_t [fpr_pkg::N_AREA-1:0] nv_write_protect_area_i,
  input wire fpr_pkg::fpr_boot_t boot_mode_i,
  input wire fpr_pkg::fpr_req_t req_i,
  input wire logic option_reload_trigger_i,
  input wire logic opt_start_i,
  input wire logic [7:0] new_read_protection_byte_i,
  input wire logic write_protect_error_clr_i,
  input wire logic option_verify_error_clr_i,
  output fpr_pkg::fpr_level_t level_o,
  output logic loaded_o,
  output logic debug_en_o,
  output logic boot_refuse_o,
  output logic grant_o,
  output logic bus_error_o,
  output logic write_protect_error_flag_o,
  output logic option_verify_error_flag_o,
  output logic mass_erase_o,
  output logic backup_erase_o,
  output logic opt_restore_o,
  output logic opt_commit_o,
  output logic opt_reject_o,
  output logic sys_reset_req_o
);

  typedef enum logic {ST_LOAD, ST_RUN} fpr_state_t;

  fpr_state_t state_reg;
  fpr_pkg::fpr_level_t level_reg;
  fpr_pkg::fpr_area_t [fpr_pkg::N_AREA-1:0] area_reg;
  fpr_pkg::fpr_level_t nv_level;
  logic nv_rdp_mismatch;
  logic [fpr_pkg::N_AREA-1:0] area_mismatch;
  logic [fpr_pkg::N_AREA-1:0] area_active;
  logic [fpr_pkg::N_AREA-1:0] area_hit;
  logic [fpr_pkg::ADDR_W-1:0] bank_base;
  logic [fpr_pkg::ADDR_W-1:0] offset;
  logic [fpr_pkg::PAGE_W-1:0] page;
  logic in_bank;
  logic restricted;
  logic is_write;
  logic page_protected;
  logic any_active;
  logic grant_next;
  logic bus_error_next;
  logic wrp_error_next;
  logic regress;
  logic run;

  fpr_rdp_decode u_rdp_decode (
    .rdp_byte_i(nv_read_protection_byte_i),
    .rdp_comp_i(nv_read_protection_comp_i),
    .level_o(nv_level),
    .mismatch_o(nv_rdp_mismatch)
  );

  assign run = (state_reg == ST_RUN);

  // Page index from the bank-relative offset, same cycle as the request
  always_comb begin
    bank_base = req_i.bank ? fpr_pkg::BANK2_BASE : fpr_pkg::BANK1_BASE;
    offset = req_i.addr - bank_base;
    page = offset[fpr_pkg::PAGE_SHIFT +: fpr_pkg::PAGE_W];
    in_bank = (req_i.addr >= bank_base) &&
              ((offset >> (fpr_pkg::PAGE_SHIFT + fpr_pkg::PAGE_W)) == '0);
  end

  // One comparator per area, areas of a bank only see their own bank
  for (genvar g = 0; g < fpr_pkg::N_AREA; g++) begin : g_area
    assign area_mismatch[g] = (nv_write_protect_area_i[g].area != ~nv_write_protect_area_i[g].area_n);
    fpr_area_match u_match (
      .area_i(area_reg[g]),
      .page_i(page),
      .in_bank_i(in_bank && (req_i.bank == ((g / fpr_pkg::AREA_PER_BANK) != 0))),
      .active_o(area_active[g]),
      .hit_o(area_hit[g])
    );
  end

  // Access decision
  always_comb begin
    is_write = (req_i.op != fpr_pkg::FPR_OP_READ);
    // Level 2 never sees debug or alternate boot, so the same gate covers it
    restricted = (level_reg != fpr_pkg::FPR_LVL0) &&
                 (req_i.from_debug || boot_mode_i != fpr_pkg::FPR_BOOT_FLASH);
    page_protected = |area_hit;
    any_active = |area_active;
    grant_next = 1'b0;
    bus_error_next = 1'b0;
    wrp_error_next = 1'b0;
    if (req_i.valid && !run) begin
      // No decision is possible before the options are loaded
      bus_error_next = 1'b1;
    end else if (req_i.valid) begin
      case (req_i.region)
        fpr_pkg::FPR_RG_MAIN: begin
          if (restricted) begin
            bus_error_next = 1'b1;
          end else if (req_i.op == fpr_pkg::FPR_OP_MASS) begin
            wrp_error_next = any_active;
            grant_next = !any_active;
          end else if (is_write && page_protected) begin
            wrp_error_next = 1'b1;
          end else begin
            grant_next = 1'b1;
          end
        end
        fpr_pkg::FPR_RG_SYSMEM: begin
          grant_next = !is_write;
          wrp_error_next = is_write;
        end
        fpr_pkg::FPR_RG_OPTION: begin
          if (is_write && level_reg == fpr_pkg::FPR_LVL2) begin
            wrp_error_next = 1'b1;
          end else begin
            grant_next = 1'b1;
          end
        end
        fpr_pkg::FPR_RG_BACKUP: begin
          bus_error_next = restricted;
          grant_next = !restricted;
        end
        fpr_pkg::FPR_RG_OTP: begin
          if (restricted) begin
            bus_error_next = 1'b1;
          end else begin
            grant_next = !is_write;
            wrp_error_next = is_write;
          end
        end
        fpr_pkg::FPR_RG_NEVER: begin
          grant_next = !is_write;
          wrp_error_next = is_write;
        end
        default: begin
          bus_error_next = 1'b1;
        end
      endcase
    end
  end

  assign regress = run && opt_start_i && level_reg == fpr_pkg::FPR_LVL1 &&
                   new_read_protection_byte_i == fpr_pkg::RDP_L0_BYTE;

  // Load after reset release: ports cannot be captured under the async reset itself
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_LOAD;
    end else if (state_reg == ST_LOAD) begin
      state_reg <= ST_RUN;
    end else if (option_reload_trigger_i) begin
      state_reg <= ST_LOAD;
    end else begin
      state_reg <= ST_RUN;
    end
  end

  // Active level and ranges change only while loading
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      level_reg <= fpr_pkg::FPR_LVL1;
    end else if (state_reg == ST_LOAD) begin
      level_reg <= nv_level;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < fpr_pkg::N_AREA; i++) begin
        area_reg[i].start_page <= fpr_pkg::AREA_NONE_START;
        area_reg[i].end_page <= fpr_pkg::AREA_NONE_END;
      end
    end else if (state_reg == ST_LOAD) begin
      for (int i = 0; i < fpr_pkg::N_AREA; i++) begin
        if (area_mismatch[i]) begin
          area_reg[i].start_page <= fpr_pkg::AREA_NONE_START;
          area_reg[i].end_page <= fpr_pkg::AREA_NONE_END;
        end else begin
          area_reg[i] <= nv_write_protect_area_i[i].area;
        end
      end
    end
  end

  // Debug and boot gating
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      debug_en_o <= 1'b0;
      boot_refuse_o <= 1'b0;
      loaded_o <= 1'b0;
      level_o <= fpr_pkg::FPR_LVL1;
    end else begin
      debug_en_o <= run && !option_reload_trigger_i &&
                    level_reg != fpr_pkg::FPR_LVL2;
      boot_refuse_o <= level_reg == fpr_pkg::FPR_LVL2 &&
                       boot_mode_i != fpr_pkg::FPR_BOOT_FLASH;
      loaded_o <= run;
      level_o <= level_reg;
    end
  end

  // Access answers, one cycle after the request
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_o <= 1'b0;
      bus_error_o <= 1'b0;
    end else begin
      grant_o <= grant_next;
      bus_error_o <= bus_error_next;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      write_protect_error_flag_o <= 1'b0;
    end else if (wrp_error_next) begin
      write_protect_error_flag_o <= 1'b1;
    end else if (write_protect_error_clr_i) begin
      write_protect_error_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      option_verify_error_flag_o <= 1'b0;
    end else if (state_reg == ST_LOAD && (nv_rdp_mismatch || |area_mismatch)) begin
      option_verify_error_flag_o <= 1'b1;
    end else if (option_verify_error_clr_i) begin
      option_verify_error_flag_o <= 1'b0;
    end
  end

  // Level change requests: the new byte only takes effect at the next reload
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mass_erase_o <= 1'b0;
      backup_erase_o <= 1'b0;
      opt_restore_o <= 1'b0;
      opt_commit_o <= 1'b0;
      opt_reject_o <= 1'b0;
    end else begin
      mass_erase_o <= regress;
      backup_erase_o <= regress;
      opt_restore_o <= regress;
      opt_commit_o <= run && opt_start_i && level_reg != fpr_pkg::FPR_LVL2;
      opt_reject_o <= run && opt_start_i && level_reg == fpr_pkg::FPR_LVL2;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_req_o <= 1'b0;
    end else begin
      sys_reset_req_o <= run && option_reload_trigger_i;
    end
  end

  sequence s_regress_req;
    run && opt_start_i && level_reg == fpr_pkg::FPR_LVL1 &&
    new_read_protection_byte_i == fpr_pkg::RDP_L0_BYTE;
  endsequence

  sequence s_erase_burst;
    mass_erase_o && backup_erase_o && opt_restore_o && opt_commit_o;
  endsequence

  sequence s_main_restricted;
    run && req_i.valid && req_i.region == fpr_pkg::FPR_RG_MAIN && restricted;
  endsequence

  a_level_decode:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    state_reg == ST_LOAD && nv_read_protection_byte_i == fpr_pkg::RDP_L2_BYTE &&
    nv_read_protection_comp_i == fpr_pkg::RDP_L2_COMP |=> level_reg == fpr_pkg::FPR_LVL2)
    else $error("level 2 pair not decoded");

  a_level_hold:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run ##1 run |-> $stable(level_reg) && $stable(area_reg))
    else $error("protection changed without reload");

  a_regress_erase:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    s_regress_req |=> s_erase_burst)
    else $error("regression did not erase");

  a_increase_noerase:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run && opt_start_i && new_read_protection_byte_i != fpr_pkg::RDP_L0_BYTE
    |=> !mass_erase_o && !backup_erase_o)
    else $error("erase on level increase");

  a_lvl2_reject:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run && opt_start_i && level_reg == fpr_pkg::FPR_LVL2 |=> opt_reject_o && !opt_commit_o)
    else $error("level 2 change not rejected");

  a_main_buserr:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    s_main_restricted |=> bus_error_o && !grant_o)
    else $error("restricted main access not faulted");

  a_sysmem_write:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run && req_i.valid && req_i.region == fpr_pkg::FPR_RG_SYSMEM && is_write
    |=> !grant_o && write_protect_error_flag_o)
    else $error("system memory write not refused");

  a_wrp_refuse:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run && req_i.valid && req_i.region == fpr_pkg::FPR_RG_MAIN && !restricted &&
    (req_i.op == fpr_pkg::FPR_OP_PROGRAM || req_i.op == fpr_pkg::FPR_OP_ERASE) && |area_hit
    |=> !grant_o ##1 write_protect_error_flag_o)
    else $error("protected page write not refused");

  a_mass_refuse:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run && req_i.valid && req_i.region == fpr_pkg::FPR_RG_MAIN && !restricted &&
    req_i.op == fpr_pkg::FPR_OP_MASS && |area_active |=> !grant_o)
    else $error("mass erase allowed with active area");

  a_debug_load:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    state_reg == ST_LOAD |=> !debug_en_o)
    else $error("debug enabled during load");

  a_lvl2_nodebug:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    level_reg == fpr_pkg::FPR_LVL2 |=> !debug_en_o)
    else $error("debug enabled at level 2");

  a_reload_reset:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run && option_reload_trigger_i |=> sys_reset_req_o && state_reg == ST_LOAD ##1 run)
    else $error("reload did not reset and reload");

  a_verify_flag:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    state_reg == ST_LOAD && nv_rdp_mismatch
    |=> option_verify_error_flag_o && level_reg == fpr_pkg::FPR_LVL1)
    else $error("option mismatch not flagged");

  a_level0_read:
  assert property (@(posedge mclk_i) disable iff (rst_i)
    run && level_reg == fpr_pkg::FPR_LVL0 && req_i.valid && !is_write |=> grant_o)
    else $error("level 0 read refused");

endmodule

//--- fpr_bus_master.sv
// Requester model for the CPU and debug port on the protection checker's access side.
// Assumes answers arrive one cycle after the request edge and the error flag is sticky.
module fpr_bus_master (
  input wire logic mclk_i,
  input wire logic grant_i,
  input wire logic bus_error_i,
  input wire logic wp_flag_i,
  output fpr_pkg::fpr_req_t req_o,
  output logic wp_clr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_o = '0;
    wp_clr_o = 1'b0;
  end

  // One-cycle request; a seen error flag is cleared as software would
  task automatic access(input logic dbg, input fpr_pkg::fpr_op_t op,
      input fpr_pkg::fpr_region_t rg, input logic [31:0] addr, output logic [2:0] ans);
    @(posedge mclk_i);
    req_o <= '{valid: 1'b1, from_debug: dbg, op: op, region: rg, bank: addr[18], addr: addr};
    @(posedge mclk_i);
    req_o.valid <= 1'b0;
    // Released address lines hold nothing useful, so show the inverse
    req_o.addr <= ~addr;
    #1;
    ans = {grant_i, bus_error_i, wp_flag_i};
    if (wp_flag_i === 1'b1) begin
      @(posedge mclk_i);
      wp_clr_o <= 1'b1;
      @(posedge mclk_i);
      wp_clr_o <= 1'b0;
    end
  endtask
endmodule

//--- tb_fpr_protect_top.sv
// Self-checking bench for the flash protection checker.
// Assumes the requester model drives req_i and clears the write-protect flag.
module tb_fpr_protect_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam fpr_pkg::fpr_op_t RD = fpr_pkg::FPR_OP_READ;
  localparam fpr_pkg::fpr_op_t PG = fpr_pkg::FPR_OP_PROGRAM;
  localparam fpr_pkg::fpr_op_t ER = fpr_pkg::FPR_OP_ERASE;
  localparam fpr_pkg::fpr_op_t MS = fpr_pkg::FPR_OP_MASS;
  localparam fpr_pkg::fpr_region_t MN = fpr_pkg::FPR_RG_MAIN;
  localparam fpr_pkg::fpr_region_t SY = fpr_pkg::FPR_RG_SYSMEM;
  localparam fpr_pkg::fpr_region_t OB = fpr_pkg::FPR_RG_OPTION;
  localparam fpr_pkg::fpr_region_t BK = fpr_pkg::FPR_RG_BACKUP;
  localparam fpr_pkg::fpr_region_t OT = fpr_pkg::FPR_RG_OTP;
  localparam fpr_pkg::fpr_region_t NW = fpr_pkg::FPR_RG_NEVER;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] nv_byte = 8'hAA;
  logic [7:0] nv_comp = 8'h55;
  fpr_pkg::fpr_area_nv_t [fpr_pkg::N_AREA-1:0] nv_area;
  fpr_pkg::fpr_boot_t boot = fpr_pkg::FPR_BOOT_FLASH;
  logic trig = 1'b0;
  logic opt_start = 1'b0;
  logic [7:0] new_byte = 8'h00;
  logic ov_clr = 1'b0;
  fpr_pkg::fpr_req_t req;
  logic wp_clr;
  fpr_pkg::fpr_level_t level;
  logic loaded, debug_en, boot_refuse, grant, bus_error, wp_flag, ov_flag;
  logic mass_erase, backup_erase, restore, commit, reject, sys_reset_req;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] dec_b [4] = '{8'h12, 8'hAA, 8'hCC, 8'hAA};
  logic [7:0] dec_c [4] = '{8'hED, 8'h54, 8'h33, 8'h55};
  fpr_pkg::fpr_level_t dec_l [4] = '{fpr_pkg::FPR_LVL1, fpr_pkg::FPR_LVL1,
      fpr_pkg::FPR_LVL2, fpr_pkg::FPR_LVL0};
  logic dec_v [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

  fpr_protect_top dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .nv_read_protection_byte_i(nv_byte),
    .nv_read_protection_comp_i(nv_comp), .nv_write_protect_area_i(nv_area),
    .boot_mode_i(boot), .req_i(req), .option_reload_trigger_i(trig),
    .opt_start_i(opt_start), .new_read_protection_byte_i(new_byte),
    .write_protect_error_clr_i(wp_clr), .option_verify_error_clr_i(ov_clr),
    .level_o(level), .loaded_o(loaded), .debug_en_o(debug_en), .boot_refuse_o(boot_refuse),
    .grant_o(grant), .bus_error_o(bus_error), .write_protect_error_flag_o(wp_flag),
    .option_verify_error_flag_o(ov_flag), .mass_erase_o(mass_erase),
    .backup_erase_o(backup_erase), .opt_restore_o(restore), .opt_commit_o(commit),
    .opt_reject_o(reject), .sys_reset_req_o(sys_reset_req)
  );

  fpr_bus_master master (
    .mclk_i(mclk_i), .grant_i(grant), .bus_error_i(bus_error), .wp_flag_i(wp_flag),
    .req_o(req), .wp_clr_o(wp_clr)
  );

  always #2 mclk_i = ~mclk_i;

  function automatic fpr_pkg::fpr_area_nv_t mk_area(input logic [6:0] s, input logic [6:0] e);
    fpr_pkg::fpr_area_nv_t a;
    a.area = '{start_page: s, end_page: e};
    a.area_n = ~a.area;
    return a;
  endfunction

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_vec(input string what, input logic [4:0] exp, input logic [4:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_lvl(input string what, input fpr_pkg::fpr_level_t exp,
      input fpr_pkg::fpr_level_t got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Answer bits are grant, bus error, write-protect flag
  task automatic acc(input string what, input logic dbg, input fpr_pkg::fpr_op_t op,
      input fpr_pkg::fpr_region_t rg, input logic [31:0] addr, input logic [2:0] exp);
    logic [2:0] ans;
    master.access(dbg, op, rg, addr, ans);
    check_vec(what, {2'b00, exp}, {2'b00, ans});
  endtask

  task automatic reload(input logic [7:0] b, input logic [7:0] c);
    @(posedge mclk_i);
    nv_byte <= b;
    nv_comp <= c;
    trig <= 1'b1;
    @(posedge mclk_i);
    trig <= 1'b0;
    #1;
    check_vec("reset request", 5'h01, {4'h0, sys_reset_req});
    repeat (4) @(posedge mclk_i);
    #1;
  endtask

  // Answer bits are commit, reject, mass erase, backup erase, restore
  task automatic opt(input logic [7:0] b, input logic [4:0] exp);
    @(posedge mclk_i);
    new_byte <= b;
    opt_start <= 1'b1;
    @(posedge mclk_i);
    opt_start <= 1'b0;
    #1;
    check_vec("option answer", exp, {commit, reject, mass_erase, backup_erase, restore});
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    nv_area[0] = mk_area(7'h02, 7'h07);
    nv_area[1] = mk_area(7'h09, 7'h09);
    nv_area[2] = mk_area(7'h05, 7'h03);
    nv_area[3] = mk_area(7'h7F, 7'h00);
    repeat (6) @(posedge mclk_i);
    check_vec("debug in reset", 5'h00, {4'h0, debug_en});
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    check_vec("loaded", 5'h01, {4'h0, loaded});
    for (int i = 0; i < 4; i++) begin
      reload(dec_b[i], dec_c[i]);
      check_lvl("decoded level", dec_l[i], level);
      check_vec("verify flag", {4'h0, dec_v[i]}, {4'h0, ov_flag});
      check_vec("debug enable", {4'h0, dec_l[i] != fpr_pkg::FPR_LVL2}, {4'h0, debug_en});
      @(posedge mclk_i);
      ov_clr <= 1'b1;
      @(posedge mclk_i);
      ov_clr <= 1'b0;
    end
    // Level 0: bank 1 areas at pages 2..7 and page 9, both bank 2 areas empty
    acc("page 2 program", 0, PG, MN, 32'h0800_1000, 3'b001);
    acc("page 1 program", 0, PG, MN, 32'h0800_0FFC, 3'b100);
    acc("page 7 erase", 0, ER, MN, 32'h0800_3FFF, 3'b001);
    acc("page 8 erase", 0, ER, MN, 32'h0800_4000, 3'b100);
    acc("page 9 program", 0, PG, MN, 32'h0800_4800, 3'b001);
    acc("page 10 program", 0, PG, MN, 32'h0800_5000, 3'b100);
    acc("bank 2 empty area", 0, PG, MN, 32'h0804_2800, 3'b100);
    acc("bank 2 page 2", 0, ER, MN, 32'h0804_1000, 3'b100);
    acc("mass with areas", 0, MS, MN, 32'h0800_0000, 3'b001);
    acc("debug main read", 1, RD, MN, 32'h0800_1000, 3'b100);
    acc("debug backup write", 1, PG, BK, 32'h0000_0000, 3'b100);
    acc("debug option write", 1, ER, OB, 32'h0000_0000, 3'b100);
    acc("sysmem read", 0, RD, SY, 32'h0000_0000, 3'b100);
    acc("sysmem program", 0, PG, SY, 32'h0000_0000, 3'b001);
    acc("sysmem erase", 1, ER, SY, 32'h0000_0000, 3'b001);
    acc("otp read", 0, RD, OT, 32'h0000_0000, 3'b100);
    acc("otp program", 0, PG, OT, 32'h0000_0000, 3'b001);
    acc("never region erase", 0, ER, NW, 32'h0000_0000, 3'b001);
    // New settings stay dormant until the next reload
    nv_area[0] <= mk_area(7'h7F, 7'h00);
    nv_area[1] <= mk_area(7'h7F, 7'h00);
    nv_byte <= 8'hCC;
    nv_comp <= 8'h33;
    repeat (3) @(posedge mclk_i);
    #1;
    check_lvl("level before reload", fpr_pkg::FPR_LVL0, level);
    acc("mass before reload", 0, MS, MN, 32'h0800_0000, 3'b001);
    opt(8'h12, 5'b10000);
    check_lvl("level after option", fpr_pkg::FPR_LVL0, level);
    reload(8'h12, 8'hED);
    acc("mass after reload", 0, MS, MN, 32'h0800_0000, 3'b100);
    acc("debug main read", 1, RD, MN, 32'h0800_5000, 3'b010);
    acc("debug backup read", 1, RD, BK, 32'h0000_0000, 3'b010);
    acc("debug sysmem read", 1, RD, SY, 32'h0000_0000, 3'b100);
    acc("debug otp read", 1, RD, OT, 32'h0000_0000, 3'b010);
    acc("user main program", 0, PG, MN, 32'h0800_5000, 3'b100);
    acc("user option write", 0, PG, OB, 32'h0000_0000, 3'b100);
    @(posedge mclk_i) boot <= fpr_pkg::FPR_BOOT_SRAM;
    acc("sram boot program", 0, PG, MN, 32'h0800_5000, 3'b010);
    @(posedge mclk_i) boot <= fpr_pkg::FPR_BOOT_SYSMEM;
    acc("loader boot erase", 0, ER, MN, 32'h0800_5000, 3'b010);
    @(posedge mclk_i) boot <= fpr_pkg::FPR_BOOT_FLASH;
    opt(8'hCC, 5'b10000);
    opt(8'hAA, 5'b10111);
    check_lvl("level kept", fpr_pkg::FPR_LVL1, level);
    reload(8'hCC, 8'h33);
    check_lvl("level 2", fpr_pkg::FPR_LVL2, level);
    check_vec("debug off", 5'h00, {4'h0, debug_en});
    @(posedge mclk_i) boot <= fpr_pkg::FPR_BOOT_SRAM;
    repeat (2) @(posedge mclk_i);
    #1;
    check_vec("boot refused", 5'h01, {4'h0, boot_refuse});
    @(posedge mclk_i) boot <= fpr_pkg::FPR_BOOT_FLASH;
    acc("level 2 user program", 0, PG, MN, 32'h0800_5000, 3'b100);
    acc("level 2 debug read", 1, RD, MN, 32'h0800_5000, 3'b010);
    acc("level 2 option write", 0, PG, OB, 32'h0000_0000, 3'b001);
    opt(8'hAA, 5'b01000);
    check_lvl("level 2 kept", fpr_pkg::FPR_LVL2, level);
    // A broken complement copy must load as an empty area and raise the verify flag
    @(posedge mclk_i) nv_area[2] <= '{area: '{start_page: 7'h00, end_page: 7'h0F}, area_n: '0};
    reload(8'hCC, 8'h33);
    check_vec("area verify flag", 5'h01, {4'h0, ov_flag});
    acc("forced empty area", 0, PG, MN, 32'h0804_0000, 3'b100);
    report_and_stop();
  end
endmodule
